// ---- spr_pkg.sv ----
package spr_pkg;

   // clock rate and the busy times of the memory operations
   localparam real CLK_MHZ = 100.0;
   localparam real T_WD_FLASH_MS = 4.5;
   localparam real T_WD_EEPROM_MS = 3.6;
   localparam real T_WD_ERASE_MS = 9.0;
   localparam int WD_FLASH_CYC = int'(T_WD_FLASH_MS * 1000.0 * CLK_MHZ);
   localparam int WD_EEPROM_CYC = int'(T_WD_EEPROM_MS * 1000.0 * CLK_MHZ);
   localparam int WD_ERASE_CYC = int'(T_WD_ERASE_MS * 1000.0 * CLK_MHZ);
   localparam int BUSY_W = 20;

   // memory geometry
   localparam int FLASH_AW = 13;
   localparam int PAGE_OFS_W = 6;
   localparam int EE_AW = 10;
   localparam int EE_OFS_W = 2;

   // first instruction byte
   localparam logic [7:0] OP_PROG = 8'hAC;
   localparam logic [7:0] OP_POLL = 8'hF0;
   localparam logic [7:0] OP_LD_EXT = 8'h4D;
   localparam logic [7:0] OP_LD_FHI = 8'h48;
   localparam logic [7:0] OP_LD_FLO = 8'h40;
   localparam logic [7:0] OP_LD_EPAGE = 8'hC1;
   localparam logic [7:0] OP_RD_FHI = 8'h28;
   localparam logic [7:0] OP_RD_FLO = 8'h20;
   localparam logic [7:0] OP_RD_EE = 8'hA0;
   localparam logic [7:0] OP_RD_LOCK = 8'h58;
   localparam logic [7:0] OP_RD_FUSE = 8'h50;
   localparam logic [7:0] OP_RD_SIG = 8'h30;
   localparam logic [7:0] OP_RD_CAL = 8'h38;
   localparam logic [7:0] OP_WR_FPAGE = 8'h4C;
   localparam logic [7:0] OP_WR_EE = 8'hC0;
   localparam logic [7:0] OP_WR_EPAGE = 8'hC2;

   // second instruction byte selectors
   localparam logic [7:0] B1_ENABLE = 8'h53;
   localparam logic [7:0] B1_ERASE = 8'h80;
   localparam logic [7:0] B1_HIGH_SEL = 8'h08;
   localparam logic [7:0] B1_WR_LOCK = 8'hE0;
   localparam logic [7:0] B1_WR_FLO = 8'hA0;
   localparam logic [7:0] B1_WR_FHI = 8'hA8;
   localparam logic [7:0] B1_WR_FEXT = 8'hA4;

   // reset and erased values
   localparam logic [7:0] FUSE_RST = 8'hFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   typedef struct packed {
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
   } spr_instr_s;

   typedef enum logic [3:0] {
      JOB_IDLE = 4'b0001,
      JOB_FPAGE = 4'b0010,
      JOB_EPAGE = 4'b0100,
      JOB_ERASE = 4'b1000
   } spr_job_e;

endpackage

// ---- spr_sync.sv ----
`timescale 1ns/1ns
module spr_sync #(
   parameter int W = 3
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] stage1;

   // two flops per pin, only the second is read outside
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clock)
         begin
            if (!nrst)
            begin
               stage1[i] <= 1'b0;
               dout[i] <= 1'b0;
            end
            else
            begin
               stage1[i] <= din[i];
               dout[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule

// ---- spr_serial_program.sv ----
// Notes on behaviour
// - data in sampled on serial clock rise
// - data out shifted on serial clock fall
// - echo 0x53 when synced; unsynced executes nothing
// - page load by 6 bits, low first
// - page write uses upper 7 address bits
// - eeprom byte write stores the byte directly
// - eeprom page alters only loaded bytes
// - reads return stored data in byte four
// - chip erase sets flash, eeprom erased
// - poll returns pending flag in bit0
// - decode load instructions by first byte
// - decode flash and eeprom reads
// - decode lock, fuse, signature, calibration reads
// - decode page and byte writes
// - AC second byte selects fuse/lock write
// - program memory addresses are word addresses
// - fuse and lock bits are active low
// - reset high ends programming, runs cpu
// - programming only while reset held low
`timescale 1ns/1ns
module spr_serial_program #(
   parameter int WD_FLASH_CYC = spr_pkg::WD_FLASH_CYC,
   parameter int WD_EEPROM_CYC = spr_pkg::WD_EEPROM_CYC,
   parameter int WD_ERASE_CYC = spr_pkg::WD_ERASE_CYC,
   parameter logic [7:0] SIG_BYTE0 = 8'h11, // arbitrary value
   parameter logic [7:0] SIG_BYTE1 = 8'h22, // arbitrary value
   parameter logic [7:0] SIG_BYTE2 = 8'h33, // arbitrary value
   parameter logic [7:0] CAL_BYTE = 8'h80
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sck,
   input wire logic mosi,
   input wire logic reset_pin_n,
   output logic miso,
   output logic miso_oe,
   output logic prog_active,
   output logic cpu_run,
   output logic operation_pending_flag
);

   localparam int FAW = spr_pkg::FLASH_AW;
   localparam int EAW = spr_pkg::EE_AW;
   localparam int POW = spr_pkg::PAGE_OFS_W;
   localparam int EOW = spr_pkg::EE_OFS_W;

   logic sck_s, mosi_s, rstpin_s, sck_d, in_prog, rise, fall;
   logic [31:0] shift;
   logic [31:0] next_shift;
   logic [2:0] bit_cnt;
   logic [1:0] byte_cnt;
   logic synced, exec, pending_w, do_cmd;
   spr_pkg::spr_instr_s cmd;
   logic [7:0] out_shift;
   logic [7:0] next_resp;
   logic [7:0] lock_bits, fuse_lo, fuse_hi, fuse_ext, ext_addr, lo_latch;
   logic [spr_pkg::BUSY_W-1:0] busy_cnt;
   spr_pkg::spr_job_e job;
   logic [FAW-1:0] walk;
   logic [FAW-POW-1:0] job_page;
   logic [EAW-EOW-1:0] job_epage;
   logic [15:0] flash [0:(1<<FAW)-1];
   logic [7:0] eeprom [0:(1<<EAW)-1];
   logic [15:0] fbuf [0:(1<<POW)-1];
   logic [7:0] ebuf [0:(1<<EOW)-1];
   logic [(1<<EOW)-1:0] emask;
   logic [FAW-1:0] rd_faddr, fjob_addr;
   logic [EAW-1:0] rd_eaddr, ee_wr_addr, ee_job_addr;
   logic [15:0] rd_word;
   logic [7:0] ee_cur;
   logic st_fpage, st_epage, st_ebyte, st_erase, job_last;

   spr_sync #(.W(3)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .din({sck, mosi, reset_pin_n}),
      .dout({sck_s, mosi_s, rstpin_s})
   );

   // programming only while the reset pin is low; clock edges found on sampled pin
   assign in_prog = !rstpin_s;
   assign rise = in_prog && sck_s && !sck_d;
   assign fall = in_prog && !sck_s && sck_d;
   assign next_shift = {shift[30:0], mosi_s};
   assign pending_w = (busy_cnt != '0) || (job != spr_pkg::JOB_IDLE);
   assign do_cmd = exec && !pending_w;

   always_ff @(posedge clock)
   begin
      if (!nrst)
         sck_d <= 1'b0;
      else
         sck_d <= sck_s;
   end

   // bit and byte framing, hunting for the enable pattern while unsynced
   always_ff @(posedge clock)
   begin
      if (!nrst || !in_prog)
      begin
         shift <= 32'h0000_0000;
         bit_cnt <= 3'd0;
         byte_cnt <= 2'd0;
         synced <= 1'b0;
         exec <= 1'b0;
         cmd <= '0;
      end
      else
      begin
         exec <= 1'b0;
         if (rise)
         begin
            shift <= next_shift;
            bit_cnt <= bit_cnt + 3'd1;
            if (!synced)
            begin
               if (next_shift[15:0] == {spr_pkg::OP_PROG, spr_pkg::B1_ENABLE})
               begin
                  synced <= 1'b1;
                  bit_cnt <= 3'd0;
                  byte_cnt <= 2'd2;
               end
            end
            else if (bit_cnt == 3'd7)
            begin
               byte_cnt <= byte_cnt + 2'd1;
               if (byte_cnt == 2'd3)
               begin
                  exec <= 1'b1;
                  cmd <= next_shift;
               end
            end
         end
      end
   end

   // read address decode from bytes two and three
   assign rd_faddr = FAW'({ext_addr, shift[15:0]});
   assign rd_eaddr = EAW'(shift[15:0]);
   assign rd_word = flash[rd_faddr];

   // response byte: echo of the last byte, or read data in byte four
   always_comb
   begin
      next_resp = shift[7:0];
      if (byte_cnt == 2'd3)
      begin
         case (shift[23:16])
            spr_pkg::OP_RD_FHI: next_resp = rd_word[15:8];
            spr_pkg::OP_RD_FLO: next_resp = rd_word[7:0];
            spr_pkg::OP_RD_EE: next_resp = eeprom[rd_eaddr];
            spr_pkg::OP_RD_LOCK: next_resp = (shift[15:8] == spr_pkg::B1_HIGH_SEL) ? fuse_hi : lock_bits;
            spr_pkg::OP_RD_FUSE: next_resp = (shift[15:8] == spr_pkg::B1_HIGH_SEL) ? fuse_ext : fuse_lo;
            spr_pkg::OP_RD_SIG:
            begin
               case (shift[1:0])
                  2'd0: next_resp = SIG_BYTE0;
                  2'd1: next_resp = SIG_BYTE1;
                  2'd2: next_resp = SIG_BYTE2;
                  default: next_resp = spr_pkg::ERASED_BYTE;
               endcase
            end
            spr_pkg::OP_RD_CAL: next_resp = CAL_BYTE;
            spr_pkg::OP_POLL: next_resp = {7'd0, pending_w};
            default: next_resp = shift[7:0];
         endcase
      end
   end

   // output shifter, loaded at a byte boundary and moved on each fall
   always_ff @(posedge clock)
   begin
      if (!nrst || !in_prog)
         out_shift <= 8'h00;
      else if (fall)
      begin
         if (bit_cnt == 3'd0)
            out_shift <= next_resp;
         else
            out_shift <= {out_shift[6:0], 1'b0};
      end
   end

   assign miso = out_shift[7];

   // write decode, ignored while an operation is pending
   assign st_fpage = do_cmd && (cmd.op == spr_pkg::OP_WR_FPAGE);
   assign st_epage = do_cmd && (cmd.op == spr_pkg::OP_WR_EPAGE);
   assign st_ebyte = do_cmd && (cmd.op == spr_pkg::OP_WR_EE);
   assign st_erase = do_cmd && (cmd.op == spr_pkg::OP_PROG) && (cmd.b1 == spr_pkg::B1_ERASE);
   assign ee_wr_addr = EAW'({cmd.b1, cmd.b2});
   assign fjob_addr = {job_page, walk[POW-1:0]};
   assign ee_job_addr = {job_epage, walk[EOW-1:0]};
   assign ee_cur = eeprom[ee_job_addr];

   always_comb
   begin
      case (job)
         spr_pkg::JOB_FPAGE: job_last = (walk[POW-1:0] == {POW{1'b1}});
         spr_pkg::JOB_EPAGE: job_last = (walk[EOW-1:0] == {EOW{1'b1}});
         spr_pkg::JOB_ERASE: job_last = (walk == {FAW{1'b1}});
         default: job_last = 1'b1;
      endcase
   end

   // page buffers, memory arrays and the commit/erase walker
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         job <= spr_pkg::JOB_IDLE;
         walk <= '0;
         job_page <= '0;
         job_epage <= '0;
         emask <= '0;
         lo_latch <= spr_pkg::ERASED_BYTE;
         ext_addr <= 8'h00;
         // unloaded buffer words must commit as erased, even on the first page
         for (int k = 0; k < (1 << POW); k++)
            fbuf[k] <= spr_pkg::ERASED_WORD;
      end
      else
      begin
         if (do_cmd)
         begin
            case (cmd.op)
               spr_pkg::OP_LD_EXT: ext_addr <= cmd.b2;
               spr_pkg::OP_LD_FLO: lo_latch <= cmd.b3;
               spr_pkg::OP_LD_FHI: fbuf[cmd.b2[POW-1:0]] <= {cmd.b3, lo_latch};
               spr_pkg::OP_LD_EPAGE:
               begin
                  ebuf[cmd.b2[EOW-1:0]] <= cmd.b3;
                  emask[cmd.b2[EOW-1:0]] <= 1'b1;
               end
               spr_pkg::OP_WR_EE: eeprom[ee_wr_addr] <= cmd.b3;
               default: ;
            endcase
         end
         case (job)
            spr_pkg::JOB_IDLE:
            begin
               walk <= '0;
               if (st_fpage)
               begin
                  job <= spr_pkg::JOB_FPAGE;
                  job_page <= rd_fpage(cmd);
               end
               else if (st_epage)
               begin
                  job <= spr_pkg::JOB_EPAGE;
                  job_epage <= ee_wr_addr[EAW-1:EOW];
               end
               else if (st_erase)
                  job <= spr_pkg::JOB_ERASE;
            end
            spr_pkg::JOB_FPAGE:
            begin
               flash[fjob_addr] <= fbuf[walk[POW-1:0]];
               fbuf[walk[POW-1:0]] <= spr_pkg::ERASED_WORD;
            end
            spr_pkg::JOB_EPAGE:
            begin
               if (emask[walk[EOW-1:0]])
                  eeprom[ee_job_addr] <= ebuf[walk[EOW-1:0]];
               if (job_last)
                  emask <= '0;
            end
            spr_pkg::JOB_ERASE:
            begin
               flash[walk] <= spr_pkg::ERASED_WORD;
               eeprom[walk[EAW-1:0]] <= spr_pkg::ERASED_BYTE;
            end
            default: job <= spr_pkg::JOB_IDLE;
         endcase
         if (job != spr_pkg::JOB_IDLE)
         begin
            walk <= walk + 1'b1;
            if (job_last)
               job <= spr_pkg::JOB_IDLE;
         end
      end
   end

   function automatic logic [FAW-POW-1:0] rd_fpage(input spr_pkg::spr_instr_s c);
      logic [FAW-1:0] wa;
      wa = FAW'({c.b1, c.b2});
      return wa[FAW-1:POW];
   endfunction

   // fuse and lock bytes; lock bits can only be programmed, erase clears them
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         lock_bits <= spr_pkg::FUSE_RST;
         fuse_lo <= spr_pkg::FUSE_RST;
         fuse_hi <= spr_pkg::FUSE_RST;
         fuse_ext <= spr_pkg::FUSE_RST;
      end
      else if (st_erase)
         lock_bits <= spr_pkg::FUSE_RST;
      else if (do_cmd && (cmd.op == spr_pkg::OP_PROG))
      begin
         case (cmd.b1)
            spr_pkg::B1_WR_LOCK: lock_bits <= lock_bits & cmd.b3;
            spr_pkg::B1_WR_FLO: fuse_lo <= cmd.b3;
            spr_pkg::B1_WR_FHI: fuse_hi <= cmd.b3;
            spr_pkg::B1_WR_FEXT: fuse_ext <= cmd.b3;
            default: ;
         endcase
      end
   end

   // busy timer for the self-timed operations
   always_ff @(posedge clock)
   begin
      if (!nrst)
         busy_cnt <= '0;
      else if (st_fpage)
         busy_cnt <= spr_pkg::BUSY_W'(WD_FLASH_CYC);
      else if (st_epage || st_ebyte)
         busy_cnt <= spr_pkg::BUSY_W'(WD_EEPROM_CYC);
      else if (st_erase)
         busy_cnt <= spr_pkg::BUSY_W'(WD_ERASE_CYC);
      else if (busy_cnt != '0)
         busy_cnt <= busy_cnt - 1'b1;
   end

   // registered status outputs
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         miso_oe <= 1'b0;
         prog_active <= 1'b0;
         cpu_run <= 1'b0;
         operation_pending_flag <= 1'b0;
      end
      else
      begin
         miso_oe <= in_prog;
         prog_active <= synced;
         cpu_run <= rstpin_s;
         operation_pending_flag <= pending_w;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_rise_sample: assert property (rise && synced |=> shift[0] == $past(mosi_s))
      else $error("data bit not taken on clock rise");
   a_out_on_fall: assert property ($changed(out_shift) |-> $past(fall) || !$past(in_prog))
      else $error("data out moved without a clock fall");
   a_enable_sync: assert property (rise && !synced && next_shift[15:0] == 16'hAC53
      |=> synced && byte_cnt == 2'd2 && bit_cnt == 3'd0)
      else $error("enable pattern did not align framing");
   a_frame_exec: assert property (synced && rise && bit_cnt == 3'd7 && byte_cnt == 2'd3
      |=> exec && byte_cnt == 2'd0)
      else $error("fourth byte did not execute");
   a_page_commit: assert property (st_fpage |=> job == spr_pkg::JOB_FPAGE ##64 job == spr_pkg::JOB_IDLE)
      else $error("flash page commit length wrong");
   a_ee_byte: assert property (st_ebyte |=> eeprom[$past(ee_wr_addr)] == $past(cmd.b3) && pending_w)
      else $error("eeprom byte not stored");
   a_ee_keep: assert property (job == spr_pkg::JOB_EPAGE && !emask[walk[EOW-1:0]]
      |=> eeprom[$past(ee_job_addr)] == $past(ee_cur))
      else $error("unloaded eeprom page byte changed");
   a_flash_read: assert property (fall && bit_cnt == 3'd0 && byte_cnt == 2'd3 && shift[23:16] == 8'h20
      |=> out_shift == $past(rd_word[7:0]))
      else $error("flash low byte read wrong");
   a_poll_flag: assert property (fall && bit_cnt == 3'd0 && byte_cnt == 2'd3 && shift[23:16] == 8'hF0
      |=> out_shift == {7'd0, $past(pending_w)})
      else $error("poll byte wrong");
   a_erase_busy: assert property (st_erase |=> pending_w [*8])
      else $error("erase not pending");
   a_prog_exit: assert property (rstpin_s |=> !synced && cpu_run)
      else $error("reset high did not leave programming");

   c_enable: cover property (rise && !synced && next_shift[15:0] == 16'hAC53);
   c_page_write: cover property (st_fpage);
   c_erase: cover property (st_erase);
   c_ee_page: cover property (st_epage ##[1:8] job == spr_pkg::JOB_IDLE);

endmodule

// ---- spr_prog_model.sv ----
`timescale 1ns/1ns
module spr_prog_model #(
   parameter int HALF = 8,
   parameter int POWER_WAIT = 60
) (
   input wire logic clock,
   input wire logic miso_line,
   output logic sck,
   output logic mosi,
   output logic reset_pin_n
);
   // power comes up with reset and serial clock both low
   initial
   begin
      sck = 1'b0;
      mosi = 1'b0;
      reset_pin_n = 1'b0;
   end

   // every change lands on a falling edge of the cpu clock
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask

   // settle time before the first enable, scaled down
   task automatic power_up();
      idle(POWER_WAIT);
   endtask

   // positive reset pulse, restarts the device framing
   task automatic pulse_reset(input int hold);
      reset_pin_n = 1'b1;
      idle(hold);
      reset_pin_n = 1'b0;
      idle(POWER_WAIT);
   endtask

   // one whole instruction, msb first; clock stands low outside frames
   task automatic xfer(input logic [31:0] ins, output logic [7:0] b3, output logic [7:0] b4);
      logic [31:0] rx;
      rx = '0;
      for (int i = 31; i >= 0; i--)
      begin
         mosi = ins[i];
         idle(HALF);
         rx[i] = miso_line; // bit shifted out at the previous fall
         sck = 1'b1;
         idle(HALF);
         sck = 1'b0;
      end
      b3 = rx[15:8];
      b4 = rx[7:0];
   endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
   logic clock, nrst, sck, mosi, reset_pin_n, miso, miso_oe;
   logic prog_active, cpu_run, operation_pending_flag, miso_line;
   logic [7:0] r3, r4;
   logic [39:0] cfg [14];
   int err_count, checked, cycles;

   // pull-up on the data out line while the device lets go of it
   assign miso_line = miso_oe ? miso : 1'b1;

   spr_serial_program #(.WD_FLASH_CYC(100), .WD_EEPROM_CYC(20), .WD_ERASE_CYC(20)) i_dut (
      .clock(clock),
      .nrst(nrst),
      .sck(sck),
      .mosi(mosi),
      .reset_pin_n(reset_pin_n),
      .miso(miso),
      .miso_oe(miso_oe),
      .prog_active(prog_active),
      .cpu_run(cpu_run),
      .operation_pending_flag(operation_pending_flag)
   );

   spr_prog_model i_prog (
      .clock(clock),
      .miso_line(miso_line),
      .sck(sck),
      .mosi(mosi),
      .reset_pin_n(reset_pin_n)
   );

   // 100 mhz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         err_count++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   // instruction, then the fourth byte returned is compared
   task automatic rd(input logic [31:0] ins, input logic [7:0] exp);
      i_prog.xfer(ins, r3, r4);
      check_byte($sformatf("read %h", ins), exp, r4);
   endtask

   task automatic run(input logic [31:0] ins);
      i_prog.xfer(ins, r3, r4);
   endtask

   // polls until the pending bit clears, bounded
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         run(32'hF000_0000);
         check_byte("poll upper bits", 8'h00, {r4[7:1], 1'b0});
         n++;
      end
      while (r4[0] !== 1'b0 && n < 40);
      check_bit("poll clears", 1'b0, r4[0]);
   endtask

   // nothing runs before the enable, then the echo shows up
   task automatic t_start();
      check_bit("cpu held", 1'b0, cpu_run);
      i_prog.power_up();
      run(32'hC000_08AA);
      i_prog.idle(8);
      check_bit("unsynced write", 1'b0, operation_pending_flag);
      check_bit("unsynced", 1'b0, prog_active);
      i_prog.pulse_reset(4);
      run(32'hAC53_0000);
      check_byte("enable echo", 8'h53, r3);
      check_bit("synced", 1'b1, prog_active);
   endtask

   // chip erase, busy seen by flag and by poll
   task automatic t_erase();
      run(32'hAC80_0000);
      i_prog.idle(6);
      check_bit("erase busy", 1'b1, operation_pending_flag);
      run(32'hF000_0000);
      check_byte("poll busy", 8'h01, r4);
      wait_idle();
      rd(32'h2000_8500, 8'hFF);
      rd(32'hA000_0800, 8'hFF);
   endtask

   // page load low then high, commit to page two
   task automatic t_flash();
      run(32'h4000_0534);
      run(32'h4800_0512);
      run(32'h4C00_8000);
      i_prog.idle(6);
      check_bit("page busy", 1'b1, operation_pending_flag);
      wait_idle();
      rd(32'h2000_8534, 8'h34);
      rd(32'h2800_8500, 8'h12);
      rd(32'h2800_8600, 8'hFF);
      rd(32'h2000_4500, 8'hFF);
   endtask

   // byte write, then a page write that touches one loaded byte only
   task automatic t_eeprom();
      run(32'hC000_083C);
      i_prog.idle(6);
      check_bit("byte busy", 1'b1, operation_pending_flag);
      wait_idle();
      rd(32'hA000_0800, 8'h3C);
      run(32'hC100_0177);
      run(32'hC200_0800);
      wait_idle();
      rd(32'hA000_0900, 8'h77);
      rd(32'hA000_0800, 8'h3C);
      rd(32'hA000_0A00, 8'hFF);
   endtask

   // reset values, writes and read-back of configuration bytes
   task automatic t_config();
      cfg = '{{32'h5800_0000, 8'hFF}, {32'h5000_0000, 8'hFF}, {32'h5808_0000, 8'hFF},
         {32'h5008_0000, 8'hFF}, {32'hACA0_00E2, 8'h00}, {32'hACA8_00D9, 8'h00},
         {32'hACA4_00FD, 8'h00}, {32'hACE0_00FC, 8'h00}, {32'h5000_0000, 8'hE2},
         {32'h5808_0000, 8'hD9}, {32'h5008_0000, 8'hFD}, {32'h5800_0000, 8'hFC},
         {32'h3000_0100, 8'h22}, {32'h3800_0000, 8'h80}};
      for (int i = 0; i < 14; i++)
      begin
         if (cfg[i][39:32] == 8'hAC)
         begin
            run(cfg[i][39:8]);
            wait_idle();
         end
         else
            rd(cfg[i][39:8], cfg[i][7:0]);
      end
      rd(32'h3000_0000, 8'h11);
      rd(32'h3000_0200, 8'h33);
   endtask

   // session end, then a fresh session keeps the memory
   task automatic t_exit();
      i_prog.reset_pin_n = 1'b1;
      i_prog.idle(8);
      check_bit("cpu runs", 1'b1, cpu_run);
      check_bit("out released", 1'b0, miso_oe);
      check_bit("sync dropped", 1'b0, prog_active);
      i_prog.reset_pin_n = 1'b0;
      i_prog.idle(8);
      check_bit("cpu held again", 1'b0, cpu_run);
      check_bit("out driven", 1'b1, miso_oe);
      i_prog.power_up();
      run(32'hAC53_0000);
      check_byte("second echo", 8'h53, r3);
      rd(32'h2000_8500, 8'h34);
   endtask

   initial
   begin
      err_count = 0;
      checked = 0;
      cycles = 0;
      nrst = 1'b0;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      t_start();
      t_erase();
      t_flash();
      t_eeprom();
      t_config();
      t_exit();
      conclude();
   end
endmodule
